// File: scc_pkg.sv
package scc_pkg;
   // register byte offsets (word aligned)
   localparam logic [7:0] SCC_OFS_CODE = 8'h00;
   localparam logic [7:0] SCC_OFS_CLKMODE = 8'h04;
   localparam logic [7:0] SCC_OFS_TC0 = 8'h08;
   localparam logic [7:0] SCC_OFS_TC1 = 8'h0C;
   localparam logic [7:0] SCC_OFS_RXCNT = 8'h10;
   localparam logic [7:0] SCC_OFS_TXCNT = 8'h14;
   localparam logic [7:0] SCC_OFS_CNTFIFO = 8'h18;
   localparam logic [7:0] SCC_OFS_STATUS = 8'h1C;
   localparam logic [7:0] SCC_OFS_TXDATA = 8'h20;
   // code register fields
   localparam int SCC_CODE_TX_LSB = 0;
   localparam int SCC_CODE_RX_LSB = 4;
   localparam int SCC_CODE_TEST_LSB = 8;
   localparam int SCC_CODE_AUTORX = 10;
   localparam int SCC_CODE_AUTOTX = 11;
   // clock mode register fields
   localparam int SCC_CM_RXSRC_LSB = 0;
   localparam int SCC_CM_TXSRC_LSB = 3;
   localparam int SCC_CM_PIN_LSB = 6;
   localparam int SCC_CM_PRE0_LSB = 9;
   localparam int SCC_CM_PRE1_LSB = 11;
   localparam int SCC_CM_RATE_LSB = 13;
   localparam int SCC_CM_PINEN_LSB = 15;
   localparam logic [31:0] SCC_RESET_ZERO = 32'h0000_0000;
   localparam int SCC_CNTFIFO_DEPTH = 4;
   localparam logic [1:0] SCC_HTRANS_NONSEQ = 2'h2;
   // line encodings
   typedef enum logic [2:0] {
      SCC_LEVEL = 3'h0, SCC_INV_LEVEL = 3'h1, SCC_MARK_TR = 3'h2, SCC_SPACE_TR = 3'h3,
      SCC_BIPH_MARK = 3'h4, SCC_BIPH_SPACE = 3'h5, SCC_BIPH_LEVEL = 3'h6, SCC_DIFF_BIPH = 3'h7
   } scc_code_t;
   // clock source choices
   typedef enum logic [2:0] {
      SCC_SRC_NONE = 3'h0, SCC_SRC_RXPIN = 3'h1, SCC_SRC_TXPIN = 3'h2, SCC_SRC_BG0 = 3'h3,
      SCC_SRC_BG1 = 3'h4, SCC_SRC_REC = 3'h5, SCC_SRC_PRE0 = 3'h6, SCC_SRC_PRE1 = 3'h7
   } scc_src_t;
   // serial link pins
   typedef struct packed {
      logic rxd;
      logic rx_clk_pin;
      logic tx_clk_pin;
   } scc_link_in_t;
   typedef struct packed {
      logic txd;
      logic clk_out;
      logic rx_clk_oe;
      logic tx_clk_oe;
   } scc_link_out_t;
endpackage

// File: scc_channel.sv
`timescale 1ns/1ps
// Overview of operation
// - eight codes, tx and rx selected separately
// - level code follows bit; inverted flips it
// - mark-transition: one toggles line at cell start
// - space-transition: zero toggles line at cell start
// - biphase mark: start edge, one adds mid
// - biphase space: start edge, zero adds mid
// - biphase level: one high-low, zero low-high
// - differential biphase: mid edge polarity tracks data
// - 16-bit rx counter, preset, decrements per character
// - message end pushes rx count into 4-FIFO
// - 16-bit tx counter, loaded, decrements per write
// - tx count zero and sent closes message
// - two baud generators, reload at zero
// - baud output toggles at half and zero
// - new time constant waits for reload
// - output is input over constant plus one
// - recovery loop counts 8/16/32 times clock
// - line transition adjusts next recovery count
// - two prescalers divide by 4/8/16/32
// - multiplexer picks sources and one pin clock
// - local loopback routes tx into receiver
// - auto echo routes rx pin to tx pin
// - no clocks connected until source programmed
module scc_channel
   import scc_pkg::*;
(
   // system
   input wire logic sys_clk,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // serial link
   input wire scc_link_in_t link_i,
   output scc_link_out_t link_o,
   // transmitter and receiver side
   input wire logic tx_bit,
   input wire logic rx_char_done,
   input wire logic rx_msg_start,
   input wire logic rx_msg_end,
   input wire logic tx_msg_start,
   input wire logic tx_char_sent,
   output logic tx_bit_take,
   output logic rx_bit,
   output logic rx_bit_valid,
   output logic tx_close_msg
);
   // bus address phase capture
   logic wr_q, wr_d, rd_q, rd_d;
   logic [7:0] adr_q, adr_d;
   // software registers
   logic [31:0] code_q, code_d, cm_q, cm_d;
   logic [15:0] tc_q [2], tc_d [2];
   logic [15:0] rxcnt_q, rxcnt_d, txcnt_q, txcnt_d;
   logic [15:0] cf_q [SCC_CNTFIFO_DEPTH], cf_d [SCC_CNTFIFO_DEPTH];
   logic [2:0] cf_n_q, cf_n_d;
   logic cf_ovf_q, cf_ovf_d;
   logic [31:0] rdata_d;
   logic tx_pending_q, tx_pending_d;
   logic close_d;
   // baud generator state
   logic [15:0] bg_cnt_q [2], bg_cnt_d [2];
   logic bg_out_q [2], bg_out_d [2];
   logic bg_tick [2];
   logic [15:0] bg_half [2];
   // prescaler state
   logic [4:0] pre_q [2], pre_d [2];
   logic pre_tick [2];
   // clock pin edge detect and mux
   logic rxp_q, txp_q;
   logic rxp_rise, txp_rise;
   logic src_tick [8];
   logic rx_os_tick, tx_os_tick;
   // recovery loop
   logic [5:0] rec_q, rec_d;
   logic [5:0] rec_len;
   logic rec_tick;
   // codec state
   logic [4:0] txph_q, txph_d;
   logic txlvl_q, txlvl_d, txb_q, txb_d, midpol_q, midpol_d;
   logic [4:0] rxph_q, rxph_d;
   logic rxa_q, rxa_d, rxprev_q, rxprev_d, rxmid_q, rxmid_d;
   logic rxb_d, rxv_d, take_d;
   logic line_rx, line_tx, cur_rx_q, cur_rx_d;
   logic pin_clk_d;
   scc_code_t transmit_clock_pin, receive_clock_pin;
   logic [4:0] half_os;

   assign transmit_clock_pin = scc_code_t'(code_q[SCC_CODE_TX_LSB +: 3]);
   assign receive_clock_pin = scc_code_t'(code_q[SCC_CODE_RX_LSB +: 3]);
   // oversampling per cell is 8/16/32, select 0..2
   assign half_os = (cm_q[SCC_CM_RATE_LSB +: 2] == 2'h0) ? 5'h04 :
                    (cm_q[SCC_CM_RATE_LSB +: 2] == 2'h1) ? 5'h08 : 5'h10;

   // bus: zero-wait slave, every access answered okay
   always_comb begin
      wr_d = hsel && hready && htrans == SCC_HTRANS_NONSEQ && hwrite;
      rd_d = hsel && hready && htrans == SCC_HTRANS_NONSEQ && !hwrite;
      adr_d = (hsel && hready) ? haddr : adr_q;
      // read data is picked in the address phase so it stands through the data phase
      case (adr_d)
         SCC_OFS_CODE: rdata_d = code_q;
         SCC_OFS_CLKMODE: rdata_d = cm_q;
         SCC_OFS_TC0: rdata_d = {16'h0000, tc_q[0]};
         SCC_OFS_TC1: rdata_d = {16'h0000, tc_q[1]};
         SCC_OFS_RXCNT: rdata_d = {16'h0000, rxcnt_q};
         SCC_OFS_TXCNT: rdata_d = {16'h0000, txcnt_q};
         SCC_OFS_CNTFIFO: rdata_d = {16'h0000, cf_q[0]};
         SCC_OFS_STATUS: rdata_d = {26'h0000000, bg_out_q[1], bg_out_q[0], cf_ovf_q, cf_n_q};
         default: rdata_d = SCC_RESET_ZERO;
      endcase
   end

   // edge pulses from pin clocks taken as synchronous inputs
   assign rxp_rise = link_i.rx_clk_pin && !rxp_q;
   assign txp_rise = link_i.tx_clk_pin && !txp_q;

   // baud generators and prescalers, one generate loop with a pass per unit
   for (genvar g = 0; g < 2; g++) begin : g_div
      // each baud generator is fed by its own prescaler
      assign bg_tick[g] = src_tick[SCC_SRC_PRE0 + g];
      // half point rounds up, so a constant of one still toggles on every input tick
      assign bg_half[g] = 16'((17'(tc_q[g]) + 17'h00001) >> 1);
      always_comb begin
         bg_cnt_d[g] = bg_cnt_q[g];
         bg_out_d[g] = bg_out_q[g];
         if (bg_tick[g]) begin
            if (bg_cnt_q[g] == 16'h0000) begin
               bg_cnt_d[g] = tc_q[g];
            end else begin
               bg_cnt_d[g] = bg_cnt_q[g] - 16'h0001;
            end
            if (bg_cnt_d[g] == 16'h0000 || bg_cnt_d[g] == bg_half[g]) begin
               bg_out_d[g] = !bg_out_q[g];
            end
         end
         // a constant of zero passes the input rate; a toggle could only halve it
         if (tc_q[g] == 16'h0000 && bg_cnt_q[g] == 16'h0000) begin
            bg_out_d[g] = bg_tick[g];
         end
         pre_d[g] = pre_q[g] + 5'h01;
      end
      // divide by 4<<sel; tick when low bits wrap
      assign pre_tick[g] = (pre_q[g] & ((5'h04 << cm_q[SCC_CM_PRE0_LSB + 2*g +: 2]) - 5'h01)) == 5'h00;
   end

   // clock multiplexer: source 0 is no clock
   always_comb begin
      src_tick[SCC_SRC_NONE] = 1'b0;
      src_tick[SCC_SRC_RXPIN] = rxp_rise;
      src_tick[SCC_SRC_TXPIN] = txp_rise;
      src_tick[SCC_SRC_BG0] = bg_tick[0] && bg_cnt_q[0] == 16'h0000;
      src_tick[SCC_SRC_BG1] = bg_tick[1] && bg_cnt_q[1] == 16'h0000;
      src_tick[SCC_SRC_REC] = rec_tick;
      src_tick[SCC_SRC_PRE0] = pre_tick[0];
      src_tick[SCC_SRC_PRE1] = pre_tick[1];
      rx_os_tick = src_tick[cm_q[SCC_CM_RXSRC_LSB +: 3]];
      tx_os_tick = src_tick[cm_q[SCC_CM_TXSRC_LSB +: 3]];
      case (cm_q[SCC_CM_PIN_LSB +: 3])
         3'h3: pin_clk_d = bg_out_q[0];
         3'h4: pin_clk_d = bg_out_q[1];
         3'h5: pin_clk_d = rec_q < {1'b0, half_os};
         3'h6: pin_clk_d = pre_tick[0];
         3'h7: pin_clk_d = pre_tick[1];
         default: pin_clk_d = 1'b0;
      endcase
   end

   // recovery loop runs off the receive source; nominal cell = 2*half_os
   assign rec_len = {half_os, 1'b0};
   assign rec_tick = rx_os_tick && rec_q == 6'h00;
   assign line_rx = (code_q[SCC_CODE_TEST_LSB +: 2] == 2'h1) ? link_o.txd : link_i.rxd;
   always_comb begin
      rec_d = rec_q;
      // line history moves only on ticks, so an edge between two ticks is still seen
      cur_rx_d = rx_os_tick ? line_rx : cur_rx_q;
      if (rx_os_tick) begin
         if (rec_q == 6'h00) begin
            rec_d = rec_len - 6'h01;
         end else if (line_rx != cur_rx_q && rec_q > {1'b0, half_os}) begin
            rec_d = rec_q - 6'h02; // late edge: shorten
         end else if (line_rx != cur_rx_q && rec_q < {1'b0, half_os}) begin
            rec_d = rec_q; // early edge: stretch one
         end else begin
            rec_d = rec_q - 6'h01;
         end
      end
   end

   // transmit encoder: one cell = 2*half_os oversampling ticks
   always_comb begin
      txph_d = txph_q;
      txlvl_d = txlvl_q;
      txb_d = txb_q;
      midpol_d = midpol_q;
      take_d = 1'b0;
      if (tx_os_tick) begin
         txph_d = (txph_q == (half_os << 1) - 5'h01) ? 5'h00 : txph_q + 5'h01;
         if (txph_q == 5'h00) begin
            txb_d = tx_bit;
            take_d = 1'b1;
            case (transmit_clock_pin)
               SCC_LEVEL: txlvl_d = tx_bit;
               SCC_INV_LEVEL: txlvl_d = !tx_bit;
               SCC_MARK_TR: txlvl_d = txlvl_q ^ tx_bit;
               SCC_SPACE_TR: txlvl_d = txlvl_q ^ !tx_bit;
               SCC_BIPH_MARK, SCC_BIPH_SPACE: txlvl_d = !txlvl_q;
               SCC_BIPH_LEVEL: txlvl_d = tx_bit;
               // mid edge goes to level midpol_next; first half is its opposite
               SCC_DIFF_BIPH: txlvl_d = midpol_q ^ !tx_bit;
               default: txlvl_d = tx_bit;
            endcase
            midpol_d = tx_bit ? !midpol_q : midpol_q;
         end else if (txph_q == half_os) begin
            case (transmit_clock_pin)
               SCC_BIPH_MARK: txlvl_d = txlvl_q ^ txb_q;
               SCC_BIPH_SPACE: txlvl_d = txlvl_q ^ !txb_q;
               SCC_BIPH_LEVEL, SCC_DIFF_BIPH: txlvl_d = !txlvl_q;
               default: txlvl_d = txlvl_q;
            endcase
         end
      end
   end
   // auto echo bypasses the encoder entirely
   assign line_tx = (code_q[SCC_CODE_TEST_LSB +: 2] == 2'h2) ? link_i.rxd : txlvl_q;

   // receive decoder: samples quarter cell and three-quarter cell
   always_comb begin
      rxph_d = rxph_q;
      rxa_d = rxa_q;
      rxprev_d = rxprev_q;
      rxmid_d = rxmid_q;
      rxb_d = 1'b0;
      rxv_d = 1'b0;
      if (rx_os_tick) begin
         rxph_d = (rxph_q == (half_os << 1) - 5'h01) ? 5'h00 : rxph_q + 5'h01;
         if (rxph_q == (half_os >> 1)) begin
            rxa_d = line_rx;
         end
         if (rxph_q == half_os + (half_os >> 1)) begin
            rxv_d = 1'b1;
            rxprev_d = line_rx;
            rxmid_d = line_rx;
            case (receive_clock_pin)
               SCC_LEVEL: rxb_d = line_rx;
               SCC_INV_LEVEL: rxb_d = !line_rx;
               SCC_MARK_TR: rxb_d = line_rx ^ rxprev_q;
               SCC_SPACE_TR: rxb_d = !(line_rx ^ rxprev_q);
               SCC_BIPH_MARK: rxb_d = rxa_q ^ line_rx;
               SCC_BIPH_SPACE: rxb_d = !(rxa_q ^ line_rx);
               SCC_BIPH_LEVEL: rxb_d = rxa_q;
               SCC_DIFF_BIPH: rxb_d = line_rx ^ rxmid_q ^ 1'b1;
               default: rxb_d = line_rx;
            endcase
         end
      end
   end

   // register writes, character counters and count fifo
   always_comb begin
      code_d = code_q;
      cm_d = cm_q;
      tc_d = tc_q;
      rxcnt_d = rxcnt_q;
      txcnt_d = txcnt_q;
      cf_d = cf_q;
      cf_n_d = cf_n_q;
      cf_ovf_d = cf_ovf_q;
      tx_pending_d = tx_pending_q;
      close_d = 1'b0;
      if (rx_char_done) begin
         rxcnt_d = rxcnt_q - 16'h0001;
      end
      if (rx_msg_start && code_q[SCC_CODE_AUTORX]) begin
         rxcnt_d = 16'hFFFF;
      end
      if (tx_msg_start && code_q[SCC_CODE_AUTOTX]) begin
         txcnt_d = tc_q[1]; // auto load from limit
      end
      // fifo read pops the oldest count
      if (rd_q && adr_q == SCC_OFS_CNTFIFO && cf_n_q != 3'h0) begin
         for (int i = 0; i < SCC_CNTFIFO_DEPTH - 1; i++) begin
            cf_d[i] = cf_q[i + 1];
         end
         cf_n_d = cf_n_q - 3'h1;
      end
      if (txcnt_q == 16'h0000 && tx_pending_q && tx_char_sent) begin
         close_d = 1'b1;
         tx_pending_d = 1'b0;
      end
      if (wr_q) begin
         case (adr_q)
            SCC_OFS_CODE: code_d = hwdata;
            SCC_OFS_CLKMODE: cm_d = hwdata;
            SCC_OFS_TC0: tc_d[0] = hwdata[15:0];
            SCC_OFS_TC1: tc_d[1] = hwdata[15:0];
            SCC_OFS_RXCNT: rxcnt_d = hwdata[15:0];
            SCC_OFS_TXCNT: txcnt_d = hwdata[15:0];
            SCC_OFS_STATUS: cf_ovf_d = cf_ovf_q && !hwdata[3]; // an overflow below still wins
            SCC_OFS_TXDATA: begin
               txcnt_d = txcnt_q - 16'h0001;
               tx_pending_d = txcnt_q == 16'h0001;
            end
            default: code_d = code_q;
         endcase
      end
      // push comes after the register write so a same-cycle overflow beats a clear
      if (rx_msg_end) begin
         if (cf_n_d == 3'h4) begin
            cf_ovf_d = 1'b1; // set wins, count dropped
         end else begin
            cf_d[cf_n_d[1:0]] = rxcnt_q;
            cf_n_d = cf_n_d + 3'h1;
         end
      end
   end

   // one registering process for all state
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_q <= 1'b0; rd_q <= 1'b0; adr_q <= 8'h00; hrdata <= SCC_RESET_ZERO;
         code_q <= SCC_RESET_ZERO; cm_q <= SCC_RESET_ZERO;
         tc_q <= '{16'h0000, 16'h0000}; bg_cnt_q <= '{16'h0000, 16'h0000};
         bg_out_q <= '{1'b0, 1'b0}; pre_q <= '{5'h00, 5'h00};
         rxcnt_q <= 16'h0000; txcnt_q <= 16'h0000;
         cf_q <= '{default: 16'h0000}; cf_n_q <= 3'h0; cf_ovf_q <= 1'b0;
         tx_pending_q <= 1'b0; tx_close_msg <= 1'b0;
         rxp_q <= 1'b0; txp_q <= 1'b0; rec_q <= 6'h00; cur_rx_q <= 1'b0;
         txph_q <= 5'h00; txlvl_q <= 1'b0; txb_q <= 1'b0; midpol_q <= 1'b0;
         rxph_q <= 5'h00; rxa_q <= 1'b0; rxprev_q <= 1'b0; rxmid_q <= 1'b0;
         rx_bit <= 1'b0; rx_bit_valid <= 1'b0; tx_bit_take <= 1'b0;
         link_o <= '0;
      end else begin
         wr_q <= wr_d; rd_q <= rd_d; adr_q <= adr_d; hrdata <= rdata_d;
         code_q <= code_d; cm_q <= cm_d; tc_q <= tc_d;
         bg_cnt_q <= bg_cnt_d; bg_out_q <= bg_out_d; pre_q <= pre_d;
         rxcnt_q <= rxcnt_d; txcnt_q <= txcnt_d;
         cf_q <= cf_d; cf_n_q <= cf_n_d; cf_ovf_q <= cf_ovf_d;
         tx_pending_q <= tx_pending_d; tx_close_msg <= close_d;
         rxp_q <= link_i.rx_clk_pin; txp_q <= link_i.tx_clk_pin;
         rec_q <= rec_d; cur_rx_q <= cur_rx_d;
         txph_q <= txph_d; txlvl_q <= txlvl_d; txb_q <= txb_d; midpol_q <= midpol_d;
         rxph_q <= rxph_d; rxa_q <= rxa_d; rxprev_q <= rxprev_d; rxmid_q <= rxmid_d;
         rx_bit <= rxb_d; rx_bit_valid <= rxv_d; tx_bit_take <= take_d;
         link_o.txd <= line_tx;
         link_o.clk_out <= pin_clk_d;
         link_o.rx_clk_oe <= cm_q[SCC_CM_PINEN_LSB];
         link_o.tx_clk_oe <= cm_q[SCC_CM_PINEN_LSB + 1];
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // clock stays disconnected while no source is chosen
   AST_NO_CLK: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cm_q[SCC_CM_RXSRC_LSB +: 3] == 3'h0 |-> !rx_os_tick) else $error("rx clock while unselected");
   // level code drives the taken bit
   AST_LEVEL: assert property (@(posedge sys_clk) disable iff (sys_rst)
      tx_os_tick && txph_q == 5'h00 && transmit_clock_pin == SCC_LEVEL && !wr_q |=> txlvl_q == $past(tx_bit))
      else $error("level code wrong");
   // mark transition flips on one
   AST_MARK: assert property (@(posedge sys_clk) disable iff (sys_rst)
      tx_os_tick && txph_q == 5'h00 && transmit_clock_pin == SCC_MARK_TR && !wr_q |=> txlvl_q == ($past(txlvl_q) ^ $past(tx_bit)))
      else $error("mark transition wrong");
   // count fifo never exceeds four
   AST_CF: assert property (@(posedge sys_clk) disable iff (sys_rst) cf_n_q <= 3'h4)
      else $error("count fifo overfilled");
   // message end stores the count
   AST_PUSH: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rx_msg_end && cf_n_q < 3'h4 && !rd_q |=> cf_n_q == $past(cf_n_q) + 3'h1) else $error("count not pushed");
   // tx write decrements counter
   AST_TXDEC: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_q && adr_q == SCC_OFS_TXDATA |=> txcnt_q == $past(txcnt_q) - 16'h0001) else $error("tx count stuck");
   // baud counter reloads the constant
   AST_RELOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bg_tick[0] && bg_cnt_q[0] == 16'h0000 && !wr_q |=> bg_cnt_q[0] == $past(tc_q[0])) else $error("no reload");
   // echo copies receive pin
   AST_ECHO: assert property (@(posedge sys_clk) disable iff (sys_rst)
      code_q[SCC_CODE_TEST_LSB +: 2] == 2'h2 && !wr_q |=> link_o.txd == $past(link_i.rxd)) else $error("echo broken");
endmodule

// File: scc_line_partner.sv
`timescale 1ns/1ps
// far-side line partner: drives receive data and keeps its pin clocks still
module scc_line_partner
   import scc_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // bench control of the line
   input wire logic drive_en,
   input wire logic drive_val,
   // line toward the channel
   output scc_link_in_t link_i
);
   logic rxd_q = 1'b0; // pattern shown while the line is released

   // a released line changes every cycle so stale data can never pass for good data
   always @(posedge sys_clk) begin
      rxd_q <= ~rxd_q;
   end

   // no frames come from this side, so both pin clocks stand still
   assign link_i = {(drive_en ? drive_val : rxd_q), 1'b0, 1'b0};
endmodule

// File: test_serial_channel_coding_clocking.sv
`timescale 1ns/1ps
// self-checking bench for one serial channel
module test_serial_channel_coding_clocking
   import scc_pkg::*;
;
   logic sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, tx_bit, drive_en, drive_val; // bench-driven controls, plus the slave's ready and response
   logic [7:0] haddr; // register byte address
   logic [1:0] htrans; // transfer kind
   logic [2:0] hsize; // always a whole word
   logic [31:0] hwdata, hrdata, rd; // bus data and last read value
   logic [4:0] ev; // char done, msg start, msg end, tx msg start, tx char sent
   scc_link_in_t link_i; // line from the partner
   scc_link_out_t link_o; // line toward the partner
   logic tx_bit_take, rx_bit, rx_bit_valid, tx_close_msg; // near-side outputs
   logic txd_q, ck_q, last_rx; // monitor history
   int error_cnt, total_checks, edges, takes, valids, rises, closes, since, last_per, cyc; // monitor counts
   int k1[8] = '{0, 0, 1, 0, 2, 1, 2, 1}; // line edges per cell, all-ones data
   int k0[8] = '{0, 0, 0, 1, 1, 2, 2, 2}; // line edges per cell, all-zeros data

   scc_channel dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link_i(link_i), .link_o(link_o), .tx_bit(tx_bit),
      .rx_char_done(ev[0]), .rx_msg_start(ev[1]), .rx_msg_end(ev[2]), .tx_msg_start(ev[3]),
      .tx_char_sent(ev[4]), .tx_bit_take(tx_bit_take), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
      .tx_close_msg(tx_close_msg));

   scc_line_partner line_u (.sys_clk(sys_clk), .drive_en(drive_en), .drive_val(drive_val), .link_i(link_i));

   // free-running clock, 40 ns period
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // counters of line edges, cells, received bits, closes and pin clock periods
   always @(posedge sys_clk) begin
      txd_q <= link_o.txd;
      ck_q <= link_o.clk_out;
      cyc <= cyc + 1;
      if (link_o.txd !== txd_q) edges <= edges + 1;
      if (tx_bit_take === 1'b1) takes <= takes + 1;
      if (tx_close_msg === 1'b1) closes <= closes + 1;
      if (rx_bit_valid === 1'b1) begin
         valids <= valids + 1;
         last_rx <= rx_bit;
      end
      // period is taken between rising edges, so pulse or square pin clocks both work
      if (link_o.clk_out === 1'b1 && ck_q === 1'b0) begin
         last_per <= since;
         since <= 1;
         rises <= rises + 1;
      end else begin
         since <= since + 1;
      end
      // a hang ends the run as a failure
      if (cyc == 40000) begin
         error_cnt = error_cnt + 1;
         close_out();
      end
   end

   // compare one value and keep the score
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic close_out();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // one single word transfer: address phase held until hready, then data phase held until hready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= SCC_HTRANS_NONSEQ;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   // read and compare only the bits under the mask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd & m, exp);
   endtask

   // one-cycle pulse on a near-side event input
   task automatic pulse(input int i);
      @(posedge sys_clk);
      ev[i] <= 1'b1;
      @(posedge sys_clk);
      ev[i] <= 1'b0;
   endtask

   // bounded wait for a monitor count; a miss shows up in the following compare
   task automatic wait_for(ref int c, input int tgt);
      int n;
      n = 0;
      while (c < tgt && n < 5000) begin
         @(posedge sys_clk);
         n = n + 1;
      end
   endtask

   // main sequence
   initial begin
      int t0, v0, r0, e0, c0;
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      tx_bit = 1'b0;
      ev = 5'h00;
      drive_en = 1'b0;
      drive_val = 1'b0;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t0 = takes;
      v0 = valids;
      r0 = rises;
      // with no source chosen neither coder nor pin clock may run
      repeat (200) @(posedge sys_clk);
      chk(takes - t0, 0);
      chk(valids - v0, 0);
      chk(rises - r0, 0);
      chk({link_o.rx_clk_oe, link_o.tx_clk_oe}, 0);
      for (int i = 0; i < 8; i++) begin
         // the two baud output bits of the status word run free from reset
         if (i != 6) rd_chk(8'(i * 4), (i == 7) ? 32'hFFFF_FFCF : 32'hFFFF_FFFF, SCC_RESET_ZERO);
      end
      // unmapped place reads zero and ignores writes
      wr(8'h24, 32'hFFFF_FFFF);
      rd_chk(8'h24, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(SCC_OFS_CODE, 32'h35);
      rd_chk(SCC_OFS_CODE, 32'hFFFF_FFFF, 32'h35);
      // prescaler 0 on the pin clock, every divide setting, both pin enables on
      for (int n = 0; n < 4; n++) begin
         wr(SCC_OFS_CLKMODE, 32'h18180 | (n << 9));
         wait_for(rises, rises + 3);
         chk(last_per, 4 << n);
      end
      chk({link_o.rx_clk_oe, link_o.tx_clk_oe}, 2'h3);
      // baud generator 0 fed by prescaler 0 at divide by four; constants grow so each lands soon
      for (int tc = 0; tc < 8; tc += 3 + (tc == 3)) begin
         wr(SCC_OFS_TC0, tc);
         wr(SCC_OFS_CLKMODE, 32'h180C0);
         wait_for(rises, rises + 4);
         chk(last_per, 4 * (tc + 1));
      end
      wr(SCC_OFS_TC1, 32'h1);
      wr(SCC_OFS_CLKMODE, 32'h18100);
      wait_for(rises, rises + 4);
      chk(last_per, 8);
      // every line code with steady ones and zeros; receive code set differently
      wr(SCC_OFS_CLKMODE, 32'h30);
      for (int c = 0; c < 8; c++) begin
         for (int b = 0; b < 2; b++) begin
            wr(SCC_OFS_CODE, ((7 - c) << 4) | c);
            tx_bit <= b[0];
            wait_for(takes, takes + 2);
            e0 = edges;
            wait_for(takes, takes + 8);
            chk((edges - e0 + 4) >> 3, b ? k1[c] : k0[c]);
            if (c < 2) chk(link_o.txd, b[0] ^ c[0]);
         end
      end
      // local loopback: the pin carries the opposite of what is sent
      wr(SCC_OFS_CODE, 32'h100);
      wr(SCC_OFS_CLKMODE, 32'h36); // both ends on prescaler 0, same cell length
      drive_en <= 1'b1;
      for (int b = 1; b >= 0; b--) begin
         tx_bit <= b[0];
         drive_val <= ~b[0];
         wait_for(valids, valids + 4);
         chk(last_rx, b[0]);
      end
      // auto echo: the receive pin shows up on the transmit pin
      wr(SCC_OFS_CODE, 32'h200);
      for (int b = 1; b >= 0; b--) begin
         drive_val <= b[0];
         for (int n = 0; n < 16 && link_o.txd !== b[0]; n++) @(posedge sys_clk);
         chk(link_o.txd, b[0]);
      end
      // recovery loop on the pin: a quiet line gives one nominal cell per period
      for (int r = 0; r < 3; r++) begin
         wr(SCC_OFS_CLKMODE, 32'h18146 | (r << 13));
         wait_for(rises, rises + 3);
         chk(last_per, 32 << r);
      end
      // a line that changes every seven ticks pulls the loop to that period
      wr(SCC_OFS_CLKMODE, 32'h18146);
      for (int n = 0; n < 24; n++) begin
         repeat (28) @(posedge sys_clk);
         drive_val <= ~drive_val;
      end
      chk(last_per, 28);
      // transmit count: no close before zero, close once after the last byte leaves
      wr(SCC_OFS_TXCNT, 32'h2);
      wr(SCC_OFS_TXDATA, 32'h41);
      c0 = closes;
      pulse(4);
      repeat (8) @(posedge sys_clk);
      chk(closes - c0, 0);
      rd_chk(SCC_OFS_TXCNT, 32'hFFFF, 32'h1);
      wr(SCC_OFS_TXDATA, 32'h42);
      rd_chk(SCC_OFS_TXCNT, 32'hFFFF, 32'h0);
      pulse(4);
      wait_for(closes, c0 + 1);
      chk(closes - c0, 1);
      wr(SCC_OFS_TC1, 32'h9);
      wr(SCC_OFS_CODE, 32'h800);
      pulse(3);
      rd_chk(SCC_OFS_TXCNT, 32'hFFFF, 32'h9);
      // receive count and its four-entry count store
      wr(SCC_OFS_RXCNT, 32'h5);
      pulse(0);
      pulse(0);
      rd_chk(SCC_OFS_RXCNT, 32'hFFFF, 32'h3);
      pulse(2);
      rd_chk(SCC_OFS_STATUS, 32'hF, 32'h1);
      rd_chk(SCC_OFS_CNTFIFO, 32'hFFFF, 32'h3);
      rd_chk(SCC_OFS_STATUS, 32'hF, 32'h0);
      wr(SCC_OFS_CODE, 32'h400);
      pulse(1);
      pulse(0);
      rd_chk(SCC_OFS_RXCNT, 32'hFFFF, 32'hFFFE);
      // a fifth message end overflows the store
      repeat (5) pulse(2);
      rd_chk(SCC_OFS_STATUS, 32'hF, 32'hC);
      wr(SCC_OFS_STATUS, 32'h8);
      rd_chk(SCC_OFS_STATUS, 32'hF, 32'h4);
      wr(SCC_OFS_TC1, 32'hFFFF);
      rd_chk(SCC_OFS_TC1, 32'hFFFF_FFFF, 32'hFFFF);
      close_out();
   end
endmodule
